// file: rtl/qsz_defines.svh
// Purpose: constants of the quick-start hold-zero sequencer, drive end and lift-control end
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: times stand in their own unit, hold-limit and speed-window cycle counts are derived from them
// Summary of operation
// - enable, direction, hold input give ready, current
// - lift control closes contactors on ready at once
// - then brake output, speed held at zero
// - lift control opens brake on brake output at once
// - speed input within 150 ms of hold release
// - speed requests only after hold request removed
// - serial hold: zero, travel, off, speed, direction bits
// - serial: travel-active bit, then brake status bit
// - serial release: intermediate/fast plus speed, zero cleared
// - held at zero over 20 s faults
// - hold request during travel faults
// - creep beyond 7 mm while holding faults
// - encoder monitor timer starts when hold ends
// - hold usable only with input configured for it
`ifndef QSZ_DEFINES_SVH
`define QSZ_DEFINES_SVH

// clock rate and timing
`define QSZ_CLK_KHZ          64'd100000
`define QSZ_HOLD_LIMIT_MS    64'd20000
`define QSZ_HOLD_LIMIT_CYC   (32'(`QSZ_HOLD_LIMIT_MS * `QSZ_CLK_KHZ))
`define QSZ_SPEED_WINDOW_MS  64'd150
`define QSZ_SPEED_WINDOW_CYC (24'(`QSZ_SPEED_WINDOW_MS * `QSZ_CLK_KHZ))
`define QSZ_ENERGISE_CYC     8'h04
`define QSZ_CREEP_LIMIT_MM   17'sh00007

// fault codes
`define QSZ_ERR_NONE         10'h000
`define QSZ_ERR_HOLD_LIMIT   10'h30c
`define QSZ_ERR_HOLD_TRAVEL  10'h30d
`define QSZ_ERR_CREEP        10'h211

// lift-control register byte addresses
`define QSZ_ADR_CTRL         8'h00
`define QSZ_ADR_STATUS       8'h04
`define QSZ_ADR_IRQ_STAT     8'h08
`define QSZ_ADR_IRQ_MASK     8'h0c

// control register fields
`define QSZ_CTRL_RUN         0
`define QSZ_CTRL_DIR_DOWN    1
`define QSZ_CTRL_SERIAL      2
`define QSZ_CTRL_DOOR_CLOSED 3
`define QSZ_CTRL_SPEED_LO    4
`define QSZ_CTRL_SPEED_HI    5
`define QSZ_CTRL_W           6

// speed selections
`define QSZ_SPD_NONE         2'h0
`define QSZ_SPD_POSITION     2'h1
`define QSZ_SPD_INTER        2'h2
`define QSZ_SPD_TRAVEL       2'h3

// interrupt status fields
`define QSZ_IRQ_READY        0
`define QSZ_IRQ_BRAKE        1
`define QSZ_IRQ_DEADLINE     2
`define QSZ_IRQ_W            3

`endif

// file: rtl/qsz_drive.sv
// Purpose: drive end, quick-start sequencing and its three fault monitors
// Assumes: position in mm from the encoder on the same clock
// Notes: normal stop sequencing is outside this block
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "qsz_defines.svh"
module qsz_drive
	import qsz_pkg::*;
#(
	parameter logic [31:0] HOLD_LIMIT_CYCLES = `QSZ_HOLD_LIMIT_CYC
)
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	qsz_link_if.drive               link,
	input  wire logic               hold_input_cfg_i,
	input  wire logic               serial_mode_i,
	input  wire logic               fault_clear_i,
	input  wire logic signed [15:0] pos_mm_i,
	output logic                    motor_current_o,
	output logic                    speed_zero_o,
	output logic                    enc_timer_start_o,
	output logic                    fault_o,
	output logic [9:0]              err_code_o
);

	qsz_drive_state_t   state_reg;
	qsz_drive_state_t   state_next;
	logic [9:0]         err_next;
	logic [31:0]        hold_cnt_reg;
	logic [7:0]         energise_cnt_reg;
	logic signed [15:0] ref_pos_reg;
	logic signed [16:0] creep;
	logic               enable;
	logic               dir_ok;
	logic               hold_req;
	logic               speed_req;
	logic               hold_timeout;
	logic               creep_fault;
	logic               ready_next;
	logic               brake_next;

	// request decode, discrete or serial form
	always_comb
	begin
		if (serial_mode_i)
		begin
			enable    = link.travel_command_bit & link.off_switch_bit;
			dir_ok    = 1'b1;
			hold_req  = hold_input_cfg_i & link.zero_rpm_cmd_bit & enable;
			speed_req = link.travel_speed_cmd_bit & ~link.zero_rpm_cmd_bit
				& (link.intermediate_speed_cmd_bit | link.fast_speed_cmd_bit);
		end
		else
		begin
			enable    = link.controller_enable_in;
			dir_ok    = |link.travel_direction_in;
			hold_req  = hold_input_cfg_i & link.hold_zero_in;
			speed_req = link.positioning_speed_in | link.intermediate_speed_in | link.travel_speed_in;
		end
	end

	// monitor conditions
	assign creep        = 17'(pos_mm_i) - 17'(ref_pos_reg);
	assign creep_fault  = (creep > `QSZ_CREEP_LIMIT_MM) || (creep < -`QSZ_CREEP_LIMIT_MM);
	assign hold_timeout = hold_cnt_reg >= HOLD_LIMIT_CYCLES;

	// sequence and fault decisions
	always_comb
	begin
		state_next = state_reg;
		err_next   = err_code_o;
		case (state_reg)
			QSZ_D_IDLE:
			begin
				err_next = `QSZ_ERR_NONE;
				if (enable && dir_ok && hold_req)
					state_next = QSZ_D_ENERGISE;
				else if (enable && dir_ok && speed_req)
					state_next = QSZ_D_TRAVEL;
			end
			QSZ_D_ENERGISE:
			begin
				if (!enable)
					state_next = QSZ_D_IDLE;
				else if (creep_fault)
				begin
					state_next = QSZ_D_FAULT;
					err_next   = `QSZ_ERR_CREEP;
				end
				else if (hold_timeout)
				begin
					state_next = QSZ_D_FAULT;
					err_next   = `QSZ_ERR_HOLD_LIMIT;
				end
				else if (energise_cnt_reg >= `QSZ_ENERGISE_CYC)
					state_next = QSZ_D_HOLD;
			end
			QSZ_D_HOLD:
			begin
				if (!enable)
					state_next = QSZ_D_IDLE;
				else if (hold_req && creep_fault)
				begin
					state_next = QSZ_D_FAULT;
					err_next   = `QSZ_ERR_CREEP;
				end
				else if (hold_timeout)
				begin
					state_next = QSZ_D_FAULT;
					err_next   = `QSZ_ERR_HOLD_LIMIT;
				end
				else if (!hold_req && speed_req)
					state_next = QSZ_D_TRAVEL;
			end
			QSZ_D_TRAVEL:
			begin
				if (hold_req)
				begin
					state_next = QSZ_D_FAULT;
					err_next   = `QSZ_ERR_HOLD_TRAVEL;
				end
				else if (!enable)
					state_next = QSZ_D_IDLE;
			end
			QSZ_D_FAULT:
			begin
				if (fault_clear_i && !enable)
				begin
					state_next = QSZ_D_IDLE;
					err_next   = `QSZ_ERR_NONE;
				end
			end
			default:
			begin
				state_next = QSZ_D_IDLE;
				err_next   = `QSZ_ERR_NONE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_reg <= QSZ_D_IDLE;
		else
			state_reg <= state_next;
	end

	// time at zero speed, counted through energising and hold
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hold_cnt_reg <= 32'h0000_0000;
		else if (state_next == QSZ_D_ENERGISE || state_next == QSZ_D_HOLD)
			hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
		else
			hold_cnt_reg <= 32'h0000_0000;
	end

	// magnetising time before the brake lifts
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			energise_cnt_reg <= 8'h00;
		else if (state_next == QSZ_D_ENERGISE)
			energise_cnt_reg <= energise_cnt_reg + 8'h01;
		else
			energise_cnt_reg <= 8'h00;
	end

	// position reference caught when the hold begins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ref_pos_reg <= 16'sh0000;
		else if (state_reg == QSZ_D_IDLE)
			ref_pos_reg <= pos_mm_i;
	end

	// output levels from the coming state
	assign ready_next = (state_next == QSZ_D_ENERGISE) || (state_next == QSZ_D_HOLD)
		|| (state_next == QSZ_D_TRAVEL);
	assign brake_next = (state_next == QSZ_D_HOLD) || (state_next == QSZ_D_TRAVEL);

	// discrete link outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			link.controller_ready_out <= 1'b0;
			link.brake_release_out    <= 1'b0;
		end
		else
		begin
			link.controller_ready_out <= ready_next;
			link.brake_release_out    <= brake_next;
		end
	end

	// serial status bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			link.travel_active_status_bit <= 1'b0;
			link.brake_status_bit         <= 1'b0;
		end
		else
		begin
			link.travel_active_status_bit <= serial_mode_i & ready_next;
			link.brake_status_bit         <= serial_mode_i & brake_next;
		end
	end

	// motor current and speed regulation target
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			motor_current_o <= 1'b0;
			speed_zero_o    <= 1'b0;
		end
		else
		begin
			motor_current_o <= ready_next;
			speed_zero_o    <= (state_next == QSZ_D_ENERGISE) || (state_next == QSZ_D_HOLD);
		end
	end

	// encoder monitor start pulse at the end of the hold
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			enc_timer_start_o <= 1'b0;
		else
			enc_timer_start_o <= (state_reg == QSZ_D_HOLD) && (state_next == QSZ_D_TRAVEL);
	end

	// fault flag and code
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fault_o    <= 1'b0;
			err_code_o <= `QSZ_ERR_NONE;
		end
		else
		begin
			fault_o    <= state_next == QSZ_D_FAULT;
			err_code_o <= err_next;
		end
	end

endmodule

// file: rtl/qsz_lift_ctrl.sv
// Purpose: lift-control end, runs the quick-start sequence on software orders
// Assumes: classic Wishbone slave, one clock
// Notes: ack comes one cycle after the strobe
`timescale 1ns/1ps
`include "qsz_defines.svh"
module qsz_lift_ctrl
	import qsz_pkg::*;
#(
	parameter logic [23:0] SPEED_WINDOW_CYCLES = `QSZ_SPEED_WINDOW_CYC
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	output logic             contactor_close_o,
	output logic             brake_open_o,
	qsz_link_if.lift         link
);

	qsz_lift_state_t             state_reg;
	qsz_lift_state_t             state_next;
	logic [`QSZ_CTRL_W-1:0]      ctrl_reg;
	logic [`QSZ_IRQ_W-1:0]       irq_stat_reg;
	logic [`QSZ_IRQ_W-1:0]       irq_mask_reg;
	logic [`QSZ_IRQ_W-1:0]       events;
	logic [23:0]                 window_cnt_reg;
	logic                        ready_seen_reg;
	logic                        brake_seen_reg;
	logic                        wr;
	logic                        serial;
	logic [1:0]                  speed_sel;
	logic                        hold_phase;
	logic                        run_phase;

	assign wr        = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
	assign serial    = ctrl_reg[`QSZ_CTRL_SERIAL];
	assign speed_sel = ctrl_reg[`QSZ_CTRL_SPEED_HI:`QSZ_CTRL_SPEED_LO];

	// sequence of the lift control
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			QSZ_L_IDLE:
				if (ctrl_reg[`QSZ_CTRL_RUN])
					state_next = QSZ_L_HOLD;
			QSZ_L_HOLD:
				if (!ctrl_reg[`QSZ_CTRL_RUN])
					state_next = QSZ_L_IDLE;
				else if (ctrl_reg[`QSZ_CTRL_DOOR_CLOSED] && brake_seen_reg)
					state_next = QSZ_L_RELEASE;
			QSZ_L_RELEASE:
				if (!ctrl_reg[`QSZ_CTRL_RUN])
					state_next = QSZ_L_IDLE;
				else if (speed_sel != `QSZ_SPD_NONE)
					state_next = QSZ_L_RUN;
				else if (window_cnt_reg >= SPEED_WINDOW_CYCLES)
					state_next = QSZ_L_ABORT;
			QSZ_L_RUN, QSZ_L_ABORT:
				if (!ctrl_reg[`QSZ_CTRL_RUN])
					state_next = QSZ_L_IDLE;
			default:
				state_next = QSZ_L_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_reg <= QSZ_L_IDLE;
		else
			state_reg <= state_next;
	end

	// time since hold release
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			window_cnt_reg <= 24'h00_0000;
		else if (state_next == QSZ_L_RELEASE)
			window_cnt_reg <= window_cnt_reg + 24'h00_0001;
		else
			window_cnt_reg <= 24'h00_0000;
	end

	assign hold_phase = state_next == QSZ_L_HOLD;
	assign run_phase  = state_next == QSZ_L_RUN;

	// discrete link outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			link.controller_enable_in  <= 1'b0;
			link.travel_direction_in   <= 2'h0;
			link.hold_zero_in          <= 1'b0;
			link.positioning_speed_in  <= 1'b0;
			link.intermediate_speed_in <= 1'b0;
			link.travel_speed_in       <= 1'b0;
		end
		else
		begin
			link.controller_enable_in  <= ~serial & (hold_phase | run_phase | state_next == QSZ_L_RELEASE);
			link.travel_direction_in   <= serial || !(hold_phase || run_phase || state_next == QSZ_L_RELEASE)
				? 2'h0 : (ctrl_reg[`QSZ_CTRL_DIR_DOWN] ? 2'h2 : 2'h1);
			link.hold_zero_in          <= ~serial & hold_phase;
			link.positioning_speed_in  <= ~serial & run_phase & (speed_sel == `QSZ_SPD_POSITION);
			link.intermediate_speed_in <= ~serial & run_phase & (speed_sel == `QSZ_SPD_INTER);
			link.travel_speed_in       <= ~serial & run_phase & (speed_sel == `QSZ_SPD_TRAVEL);
		end
	end

	// serial command bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			link.zero_rpm_cmd_bit           <= 1'b0;
			link.travel_command_bit         <= 1'b0;
			link.off_switch_bit             <= 1'b0;
			link.travel_speed_cmd_bit       <= 1'b0;
			link.travel_direction_bit       <= 1'b0;
			link.intermediate_speed_cmd_bit <= 1'b0;
			link.fast_speed_cmd_bit         <= 1'b0;
		end
		else
		begin
			link.zero_rpm_cmd_bit     <= serial & hold_phase;
			link.travel_command_bit   <= serial & (hold_phase | run_phase | state_next == QSZ_L_RELEASE);
			link.off_switch_bit       <= serial & (hold_phase | run_phase | state_next == QSZ_L_RELEASE);
			link.travel_speed_cmd_bit <= serial & (hold_phase | run_phase);
			link.travel_direction_bit <= serial & ctrl_reg[`QSZ_CTRL_DIR_DOWN];
			link.intermediate_speed_cmd_bit <= serial & run_phase & (speed_sel != `QSZ_SPD_TRAVEL);
			link.fast_speed_cmd_bit   <= serial & run_phase & (speed_sel == `QSZ_SPD_TRAVEL);
		end
	end

	// contactors and brake follow the drive outputs at once
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			contactor_close_o <= 1'b0;
			brake_open_o      <= 1'b0;
			ready_seen_reg    <= 1'b0;
			brake_seen_reg    <= 1'b0;
		end
		else
		begin
			contactor_close_o <= link.controller_ready_out | link.travel_active_status_bit;
			brake_open_o      <= link.brake_release_out | link.brake_status_bit;
			ready_seen_reg    <= link.controller_ready_out | link.travel_active_status_bit;
			brake_seen_reg    <= link.brake_release_out | link.brake_status_bit;
		end
	end

	// interrupt events
	assign events[`QSZ_IRQ_READY]    = (link.controller_ready_out | link.travel_active_status_bit) & ~ready_seen_reg;
	assign events[`QSZ_IRQ_BRAKE]    = (link.brake_release_out | link.brake_status_bit) & ~brake_seen_reg;
	assign events[`QSZ_IRQ_DEADLINE] = (state_reg == QSZ_L_RELEASE) && (state_next == QSZ_L_ABORT);

	// registers, write-one-to-clear status, set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_reg     <= 6'h00;
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
		end
		else
		begin
			if (wr && wb_adr_i == `QSZ_ADR_CTRL)
				ctrl_reg <= wb_dat_i[`QSZ_CTRL_W-1:0];
			if (wr && wb_adr_i == `QSZ_ADR_IRQ_MASK)
				irq_mask_reg <= wb_dat_i[`QSZ_IRQ_W-1:0];
			if (wr && wb_adr_i == `QSZ_ADR_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[`QSZ_IRQ_W-1:0]) | events;
			else
				irq_stat_reg <= irq_stat_reg | events;
		end
	end

	// bus answer and interrupt line
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			irq_o    <= 1'b0;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			irq_o    <= |((irq_stat_reg | events) & irq_mask_reg);
			case (wb_adr_i)
				`QSZ_ADR_CTRL:     wb_dat_o <= {26'h000_0000, ctrl_reg};
				`QSZ_ADR_STATUS:   wb_dat_o <= {25'h000_0000, state_reg, brake_seen_reg, ready_seen_reg};
				`QSZ_ADR_IRQ_STAT: wb_dat_o <= {29'h000_0000, irq_stat_reg};
				`QSZ_ADR_IRQ_MASK: wb_dat_o <= {29'h000_0000, irq_mask_reg};
				default:           wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// file: rtl/qsz_link_if.sv
// Purpose: link between lift control and drive, discrete and serial-bit forms
// Assumes: both ends on the same clock
// Notes: plain wires, no clocking block
`timescale 1ns/1ps
interface qsz_link_if;
	// discrete inputs of the drive
	logic       controller_enable_in;
	logic [1:0] travel_direction_in;
	logic       hold_zero_in;
	logic       positioning_speed_in;
	logic       intermediate_speed_in;
	logic       travel_speed_in;
	// discrete outputs of the drive
	logic       controller_ready_out;
	logic       brake_release_out;
	// serial command bits
	logic       zero_rpm_cmd_bit;
	logic       intermediate_speed_cmd_bit;
	logic       fast_speed_cmd_bit;
	logic       travel_command_bit;
	logic       off_switch_bit;
	logic       travel_speed_cmd_bit;
	logic       travel_direction_bit;
	// serial status bits
	logic       travel_active_status_bit;
	logic       brake_status_bit;

	modport drive
	(
		input  controller_enable_in, travel_direction_in, hold_zero_in,
		input  positioning_speed_in, intermediate_speed_in, travel_speed_in,
		input  zero_rpm_cmd_bit, intermediate_speed_cmd_bit, fast_speed_cmd_bit,
		input  travel_command_bit, off_switch_bit, travel_speed_cmd_bit, travel_direction_bit,
		output controller_ready_out, brake_release_out, travel_active_status_bit, brake_status_bit
	);

	modport lift
	(
		output controller_enable_in, travel_direction_in, hold_zero_in,
		output positioning_speed_in, intermediate_speed_in, travel_speed_in,
		output zero_rpm_cmd_bit, intermediate_speed_cmd_bit, fast_speed_cmd_bit,
		output travel_command_bit, off_switch_bit, travel_speed_cmd_bit, travel_direction_bit,
		input  controller_ready_out, brake_release_out, travel_active_status_bit, brake_status_bit
	);
endinterface

// file: rtl/qsz_pkg.sv
// Purpose: state types of both ends
// Assumes: one-hot encodings
// Notes: numbers live in qsz_defines.svh
package qsz_pkg;

	typedef enum logic [4:0]
	{
		QSZ_D_IDLE     = 5'h01,
		QSZ_D_ENERGISE = 5'h02,
		QSZ_D_HOLD     = 5'h04,
		QSZ_D_TRAVEL   = 5'h08,
		QSZ_D_FAULT    = 5'h10
	} qsz_drive_state_t;

	typedef enum logic [4:0]
	{
		QSZ_L_IDLE    = 5'h01,
		QSZ_L_HOLD    = 5'h02,
		QSZ_L_RELEASE = 5'h04,
		QSZ_L_RUN     = 5'h08,
		QSZ_L_ABORT   = 5'h10
	} qsz_lift_state_t;

endpackage

// file: verification/qsz_monitor.sv
// Purpose: checks on the first link of the quick-start pair
// Assumes: one clock, synchronous active-high reset
// Notes: sees link signals and a few drive and lift pins
`timescale 1ns/1ps
module qsz_monitor
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       controller_enable_in,
	input wire logic [1:0] travel_direction_in,
	input wire logic       hold_zero_in,
	input wire logic       zero_rpm_cmd_bit,
	input wire logic       travel_command_bit,
	input wire logic       controller_ready_out,
	input wire logic       brake_release_out,
	input wire logic       travel_active_status_bit,
	input wire logic       brake_status_bit,
	input wire logic       contactor_close_o,
	input wire logic       brake_open_o,
	input wire logic       motor_current_o,
	input wire logic       speed_zero_o,
	input wire logic       enc_timer_start_o,
	input wire logic       fault_o
);
	// all checks on the one clock
	default clocking mcb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// start-up order and its causes
	ready_cause_a: assert property ($rose(controller_ready_out) |->
		($past(controller_enable_in) && $past(travel_direction_in) != 2'h0) || $past(travel_command_bit))
		else $error("ready without request");
	brake_after_ready_a: assert property ($rose(brake_release_out) |->
		$past(controller_ready_out) && motor_current_o) else $error("brake before ready");
	zero_hold_a: assert property (hold_zero_in && brake_release_out |-> speed_zero_o)
		else $error("speed not held at zero");
	contactor_a: assert property ($rose(controller_ready_out) |=> contactor_close_o)
		else $error("contactor late");
	brake_open_a: assert property ($rose(brake_release_out) |=> brake_open_o)
		else $error("brake open late");
	serial_order_a: assert property ($rose(brake_status_bit) |-> $past(travel_active_status_bit))
		else $error("brake bit before travel bit");
	fault_off_a: assert property (fault_o |->
		!(controller_ready_out || brake_release_out || motor_current_o)) else $error("outputs on in fault");
	enc_start_a: assert property (enc_timer_start_o |-> !hold_zero_in && !zero_rpm_cmd_bit)
		else $error("encoder timer started in hold");

	// main scenarios reached
	cover property ($rose(brake_release_out));
	cover property ($rose(brake_status_bit));
	cover property ($rose(fault_o));
endmodule

// file: verification/quick_start_hold_zero_sequencer_tb_top.sv
// Purpose: self-checking bench for the quick-start pair
// Assumes: shortened hold limit and speed window
// Notes: a spare drive end on a second link is driven directly
`timescale 1ns/1ps
`include "qsz_defines.svh"
module quick_start_hold_zero_sequencer_tb_top;
	localparam logic [31:0] HL = 32'd200;
	localparam logic [23:0] SW = 24'd50;
	logic               clk_i;
	logic               rst_i = 1'b1;
	logic               cyc = 1'b0, stb = 1'b0, we = 1'b0, cfg = 1'b1, ser = 1'b0, fclr = 1'b0;
	logic               cfg_b = 1'b0, fclr_b = 1'b0;
	logic [7:0]         adr = 8'h00;
	logic [31:0]        wdat = 32'h0, rdat, rd;
	logic               ack, irq, cont, bopen, cur, sz, enc, flt, cur_b, sz_b, enc_b, flt_b;
	logic signed [15:0] pos = 16'sh0000;
	logic [9:0]         err, err_b;
	int                 err_count = 0, checks_done = 0, cycles = 0;

	qsz_link_if qsz_link_if_i();
	qsz_link_if qsz_link_if_b_i();
	qsz_lift_ctrl #(.SPEED_WINDOW_CYCLES(SW)) qsz_lift_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq), .contactor_close_o(cont), .brake_open_o(bopen), .link(qsz_link_if_i.lift));
	qsz_drive #(.HOLD_LIMIT_CYCLES(HL)) qsz_drive_i (.clk_i(clk_i), .rst_i(rst_i), .link(qsz_link_if_i.drive),
		.hold_input_cfg_i(cfg), .serial_mode_i(ser), .fault_clear_i(fclr), .pos_mm_i(pos), .motor_current_o(cur),
		.speed_zero_o(sz), .enc_timer_start_o(enc), .fault_o(flt), .err_code_o(err));
	qsz_drive #(.HOLD_LIMIT_CYCLES(HL)) qsz_drive_b_i (.clk_i(clk_i), .rst_i(rst_i), .link(qsz_link_if_b_i.drive),
		.hold_input_cfg_i(cfg_b), .serial_mode_i(1'b0), .fault_clear_i(fclr_b), .pos_mm_i(16'sh0000),
		.motor_current_o(cur_b), .speed_zero_o(sz_b), .enc_timer_start_o(enc_b), .fault_o(flt_b), .err_code_o(err_b));
	qsz_monitor qsz_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
		.controller_enable_in(qsz_link_if_i.controller_enable_in),
		.travel_direction_in(qsz_link_if_i.travel_direction_in), .hold_zero_in(qsz_link_if_i.hold_zero_in),
		.zero_rpm_cmd_bit(qsz_link_if_i.zero_rpm_cmd_bit), .travel_command_bit(qsz_link_if_i.travel_command_bit),
		.controller_ready_out(qsz_link_if_i.controller_ready_out),
		.brake_release_out(qsz_link_if_i.brake_release_out),
		.travel_active_status_bit(qsz_link_if_i.travel_active_status_bit),
		.brake_status_bit(qsz_link_if_i.brake_status_bit), .contactor_close_o(cont), .brake_open_o(bopen),
		.motor_current_o(cur), .speed_zero_o(sz), .enc_timer_start_o(enc), .fault_o(flt));

	// clock
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// watchdog against a hang
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			err_count++;
			final_report();
		end
	end

	task automatic final_report();
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one classic bus cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// bounded wait for a level, then judged
	task automatic wait_hi(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1 && n < lim)
		begin
			@(posedge clk_i);
			n++;
		end
		check(s, 1'b1);
	endtask

	// end a sequence and clear any fault
	task automatic stop();
		wb(1'b1, `QSZ_ADR_CTRL, 32'h0);
		@(posedge clk_i);
		fclr <= 1'b1;
		pos <= 16'sh0000;
		repeat (4) @(posedge clk_i);
		fclr <= 1'b0;
		@(posedge clk_i);
		check(flt, 1'b0);
		check(err, `QSZ_ERR_NONE);
	endtask

	task automatic t_regs();
		logic [31:0] e [5];
		e = '{32'h0, 32'h4, 32'h0, 32'h0, 32'h0};
		for (int p = 0; p < 2; p++)
		begin
			for (int i = 0; i < 5; i++)
			begin
				wb(1'b0, 8'(i * 4), 32'h0);
				check(rd, e[i]);
			end
			wb(1'b1, `QSZ_ADR_STATUS, 32'hff);
			wb(1'b1, 8'h10, 32'hff);
			wb(1'b1, `QSZ_ADR_IRQ_MASK, 32'h5);
			e[3] = 32'h5;
		end
	endtask

	task automatic t_quick();
		wb(1'b1, `QSZ_ADR_IRQ_MASK, 32'h3);
		wb(1'b1, `QSZ_ADR_CTRL, 32'h1);
		wait_hi(qsz_link_if_i.brake_release_out, 20);
		check(qsz_link_if_i.controller_ready_out, 1'b1);
		check(cur, 1'b1);
		check(sz, 1'b1);
		@(posedge clk_i);
		check(bopen, 1'b1);
		check(cont, 1'b1);
		wb(1'b0, `QSZ_ADR_IRQ_STAT, 32'h0);
		check(rd, 32'h3);
		check(irq, 1'b1);
		wb(1'b1, `QSZ_ADR_IRQ_STAT, 32'h3);
		wb(1'b0, `QSZ_ADR_IRQ_STAT, 32'h0);
		check(rd, 32'h0);
		check(irq, 1'b0);
		wb(1'b1, `QSZ_ADR_CTRL, 32'h39);
		wait_hi(enc, 10);
		check(sz, 1'b0);
		check({qsz_link_if_i.positioning_speed_in, qsz_link_if_i.intermediate_speed_in,
			qsz_link_if_i.travel_speed_in}, 3'h1);
		check(qsz_link_if_i.hold_zero_in, 1'b0);
		stop();
	endtask

	task automatic t_limit();
		wb(1'b1, `QSZ_ADR_CTRL, 32'h1);
		repeat (180) @(posedge clk_i);
		check(flt, 1'b0);
		wait_hi(flt, 40);
		check(err, `QSZ_ERR_HOLD_LIMIT);
		@(posedge clk_i);
		check({qsz_link_if_i.controller_ready_out, qsz_link_if_i.brake_release_out, cur}, 3'h0);
		stop();
	endtask

	task automatic t_creep();
		wb(1'b1, `QSZ_ADR_CTRL, 32'h1);
		wait_hi(qsz_link_if_i.brake_release_out, 20);
		pos <= 16'sh0007;
		repeat (5) @(posedge clk_i);
		check(flt, 1'b0);
		pos <= -16'sh0008;
		wait_hi(flt, 5);
		check(err, `QSZ_ERR_CREEP);
		stop();
	endtask

	// door closed but no speed: lift gives up
	task automatic t_abort();
		wb(1'b1, `QSZ_ADR_IRQ_MASK, 32'h4);
		wb(1'b1, `QSZ_ADR_CTRL, 32'h1);
		wait_hi(qsz_link_if_i.brake_release_out, 20);
		wb(1'b1, `QSZ_ADR_CTRL, 32'h9);
		repeat (40) @(posedge clk_i);
		check(irq, 1'b0);
		wait_hi(irq, 30);
		check(qsz_link_if_i.controller_enable_in, 1'b0);
		stop();
		wb(1'b1, `QSZ_ADR_IRQ_STAT, 32'h7);
		repeat (2) @(posedge clk_i);
		check(irq, 1'b0);
	endtask

	task automatic t_serial();
		ser <= 1'b1;
		wb(1'b1, `QSZ_ADR_CTRL, 32'h7);
		wait_hi(qsz_link_if_i.brake_status_bit, 20);
		check(qsz_link_if_i.travel_active_status_bit, 1'b1);
		check({qsz_link_if_i.zero_rpm_cmd_bit, qsz_link_if_i.travel_command_bit}, 2'h3);
		check({qsz_link_if_i.off_switch_bit, qsz_link_if_i.travel_speed_cmd_bit}, 2'h3);
		check(qsz_link_if_i.travel_direction_bit, 1'b1);
		wb(1'b1, `QSZ_ADR_CTRL, 32'h2f);
		wait_hi(enc, 10);
		check({qsz_link_if_i.zero_rpm_cmd_bit, qsz_link_if_i.intermediate_speed_cmd_bit,
			qsz_link_if_i.fast_speed_cmd_bit}, 3'h2);
		stop();
		ser <= 1'b0;
	endtask

	// spare drive: unconfigured hold, then hold during travel
	task automatic t_far();
		qsz_link_if_b_i.controller_enable_in <= 1'b1;
		qsz_link_if_b_i.travel_direction_in <= 2'h1;
		qsz_link_if_b_i.hold_zero_in <= 1'b1;
		repeat (10) @(posedge clk_i);
		check(qsz_link_if_b_i.controller_ready_out, 1'b0);
		cfg_b <= 1'b1;
		wait_hi(qsz_link_if_b_i.brake_release_out, 20);
		qsz_link_if_b_i.hold_zero_in <= 1'b0;
		@(posedge clk_i);
		qsz_link_if_b_i.travel_speed_in <= 1'b1;
		wait_hi(enc_b, 5);
		check(sz_b, 1'b0);
		qsz_link_if_b_i.hold_zero_in <= 1'b1;
		wait_hi(flt_b, 5);
		check(err_b, `QSZ_ERR_HOLD_TRAVEL);
		@(posedge clk_i);
		check(cur_b, 1'b0);
		qsz_link_if_b_i.controller_enable_in <= 1'b0;
		fclr_b <= 1'b1;
		repeat (4) @(posedge clk_i);
		check(err_b, `QSZ_ERR_NONE);
	endtask

	// main sequence
	initial
	begin
		{qsz_link_if_b_i.controller_enable_in, qsz_link_if_b_i.travel_direction_in, qsz_link_if_b_i.hold_zero_in,
			qsz_link_if_b_i.positioning_speed_in, qsz_link_if_b_i.intermediate_speed_in,
			qsz_link_if_b_i.travel_speed_in, qsz_link_if_b_i.zero_rpm_cmd_bit,
			qsz_link_if_b_i.intermediate_speed_cmd_bit, qsz_link_if_b_i.fast_speed_cmd_bit,
			qsz_link_if_b_i.travel_command_bit, qsz_link_if_b_i.off_switch_bit,
			qsz_link_if_b_i.travel_speed_cmd_bit, qsz_link_if_b_i.travel_direction_bit} = 14'h0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_quick();
		t_limit();
		t_creep();
		t_abort();
		t_serial();
		t_far();
		final_report();
	end
endmodule
